// [converter_mode_pin_control.sv]
// Mode selection and self-trim sequencing for a dual-channel converter.
// Assumes static mode pins from board logic, a one-cycle strobe register port,
// and that the serial shifter outside presents decoded register accesses here.
`timescale 1ns/1ps

module converter_mode_pin_control #(
    parameter int POWERON_SHORT_CYC = mode_ctrl_pkg::POWERON_SHORT_CYC,
    parameter int POWERON_LONG_CYC = mode_ctrl_pkg::POWERON_LONG_CYC,
    parameter int TRIM_RUN_CYC = mode_ctrl_pkg::TRIM_RUN_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire mode_ctrl_pkg::mode_pins_t mode_pins,
    input wire logic [mode_ctrl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [mode_ctrl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [mode_ctrl_pkg::DATA_W-1:0] reg_rdata,
    output logic selftrim_active,
    output mode_ctrl_pkg::mode_out_t mode_settings,
    output logic irq
);

    localparam int CW = mode_ctrl_pkg::CNT_W;
    localparam int RW = mode_ctrl_pkg::RANGE_W;
    localparam int IW = mode_ctrl_pkg::IRQ_W;
    localparam int DW = mode_ctrl_pkg::DATA_W;

    localparam logic [CW-1:0] LOW_LAST = CW'(mode_ctrl_pkg::TRIGGER_MIN_LOW_CYC);
    localparam logic [CW-1:0] HIGH_LAST = CW'(mode_ctrl_pkg::TRIGGER_MIN_HIGH_CYC - 1);
    localparam logic [CW-1:0] SHORT_LAST = CW'(POWERON_SHORT_CYC - 1);
    localparam logic [CW-1:0] LONG_LAST = CW'(POWERON_LONG_CYC - 1);
    localparam logic [CW-1:0] RUN_LAST = CW'(TRIM_RUN_CYC - 1);

    mode_ctrl_pkg::mode_pins_t pins_meta_ff;
    mode_ctrl_pkg::mode_pins_t pins_ff;
    mode_ctrl_pkg::mode_out_t mode_settings_ff;
    mode_ctrl_pkg::mode_out_t nxt_mode_settings;
    mode_ctrl_pkg::trim_state_t state_ff;
    mode_ctrl_pkg::trim_state_t nxt_state;

    logic register_control_mode;
    logic trigger_bit_ff;
    logic phase_bit_ff;
    logic interleave_bit_ff;
    logic [RW-1:0] range_ff [mode_ctrl_pkg::CHANNELS];
    logic [RW-1:0] nxt_range [mode_ctrl_pkg::CHANNELS];

    logic trigger_request;
    logic trigger_armed_ff;
    logic [CW-1:0] low_cnt_ff;
    logic [CW-1:0] high_cnt_ff;
    logic trim_command;

    logic [CW-1:0] wait_cnt_ff;
    logic [CW-1:0] poweron_last;
    logic selftrim_active_ff;
    logic trim_start;
    logic trim_done;

    logic [IW-1:0] irq_status_ff;
    logic [IW-1:0] irq_enable_ff;
    logic [IW-1:0] irq_events;
    logic [IW-1:0] irq_clear;
    logic [IW-1:0] nxt_irq_status;
    logic irq_ff;
    logic [DW-1:0] reg_rdata_ff;

    // Pin synchroniser; the first stage feeds only the second
    always_ff @(posedge clk) begin
        if (reset) begin
            // Idle pin levels, so release of reset raises no false mode change
            pins_meta_ff <= mode_ctrl_pkg::PINS_RESET;
            pins_ff <= mode_ctrl_pkg::PINS_RESET;
        end else begin
            pins_meta_ff <= mode_pins;
            pins_ff <= pins_meta_ff;
        end
    end

    assign register_control_mode = ~pins_ff.extended_control_enable_n;

    // Control register bits; held at defaults whenever pin control is selected
    always_ff @(posedge clk) begin
        if (reset || !register_control_mode) begin
            trigger_bit_ff <= 1'b0;
            phase_bit_ff <= 1'b0;
            interleave_bit_ff <= 1'b0;
        end else if (reg_write && reg_addr == mode_ctrl_pkg::ADDR_CONFIG) begin
            trigger_bit_ff <= reg_wdata[mode_ctrl_pkg::CFG_TRIGGER_BIT];
            phase_bit_ff <= reg_wdata[mode_ctrl_pkg::CFG_PHASE_BIT];
            interleave_bit_ff <= reg_wdata[mode_ctrl_pkg::CFG_INTERLEAVE_BIT];
        end
    end

    // Per-channel range registers
    always_ff @(posedge clk) begin
        if (reset || !register_control_mode) begin
            range_ff[0] <= mode_ctrl_pkg::RANGE_RESET;
            range_ff[1] <= mode_ctrl_pkg::RANGE_RESET;
        end else if (reg_write) begin
            if (reg_addr == mode_ctrl_pkg::ADDR_RANGE_I) begin
                range_ff[0] <= reg_wdata[RW-1:0];
            end
            if (reg_addr == mode_ctrl_pkg::ADDR_RANGE_Q) begin
                range_ff[1] <= reg_wdata[RW-1:0];
            end
        end
    end

    // The bit only counts in register mode, so a stale bit cannot fire in pin mode
    assign trigger_request = pins_ff.trigger | (register_control_mode & trigger_bit_ff);

    // A start needs a full low interval before a full high interval
    assign trim_command = trigger_request && trigger_armed_ff && high_cnt_ff == HIGH_LAST;

    always_ff @(posedge clk) begin
        if (reset) begin
            low_cnt_ff <= '0;
            high_cnt_ff <= '0;
            trigger_armed_ff <= 1'b0;
        end else if (!trigger_request) begin
            high_cnt_ff <= '0;
            if (low_cnt_ff != LOW_LAST) begin
                low_cnt_ff <= low_cnt_ff + 1'b1;
            end else begin
                trigger_armed_ff <= 1'b1;
            end
        end else begin
            low_cnt_ff <= '0;
            if (trim_command) begin
                trigger_armed_ff <= 1'b0;
                high_cnt_ff <= '0;
            end else if (trigger_armed_ff) begin
                high_cnt_ff <= high_cnt_ff + 1'b1;
            end
        end
    end

    // Wait select is read live so a late strap change still counts
    assign poweron_last = pins_ff.wait_select ? LONG_LAST : SHORT_LAST;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            mode_ctrl_pkg::ST_SETTLE: begin
                if (wait_cnt_ff == mode_ctrl_pkg::SETTLE_LAST) begin
                    // Trigger high at power-on cancels the automatic trim
                    nxt_state = trigger_request ? mode_ctrl_pkg::ST_IDLE
                                                : mode_ctrl_pkg::ST_PWR_WAIT;
                end
            end
            mode_ctrl_pkg::ST_PWR_WAIT: begin
                if (trim_command || wait_cnt_ff == poweron_last) begin
                    nxt_state = mode_ctrl_pkg::ST_RUN;
                end
            end
            mode_ctrl_pkg::ST_IDLE: begin
                if (trim_command) begin
                    nxt_state = mode_ctrl_pkg::ST_RUN;
                end
            end
            mode_ctrl_pkg::ST_RUN: begin
                // Requests during a running trim are dropped, not queued
                if (wait_cnt_ff == RUN_LAST) begin
                    nxt_state = mode_ctrl_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= mode_ctrl_pkg::ST_SETTLE;
            wait_cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            if (nxt_state != state_ff) begin
                wait_cnt_ff <= '0;
            end else if (state_ff != mode_ctrl_pkg::ST_IDLE) begin
                wait_cnt_ff <= wait_cnt_ff + 1'b1;
            end
        end
    end

    assign trim_start = nxt_state == mode_ctrl_pkg::ST_RUN && state_ff != mode_ctrl_pkg::ST_RUN;
    assign trim_done = state_ff == mode_ctrl_pkg::ST_RUN && nxt_state != mode_ctrl_pkg::ST_RUN;

    always_ff @(posedge clk) begin
        if (reset) begin
            selftrim_active_ff <= 1'b0;
        end else begin
            selftrim_active_ff <= nxt_state == mode_ctrl_pkg::ST_RUN;
        end
    end

    // Range selection, identical for each channel
    for (genvar ch = 0; ch < mode_ctrl_pkg::CHANNELS; ch++) begin : g_range
        always_comb begin
            if (register_control_mode) begin
                nxt_range[ch] = range_ff[ch];
            end else if (pins_ff.range) begin
                nxt_range[ch] = mode_ctrl_pkg::RANGE_MID;
            end else begin
                nxt_range[ch] = mode_ctrl_pkg::RANGE_MIN;
            end
        end
    end

    always_comb begin
        nxt_mode_settings.register_control_mode = register_control_mode;
        nxt_mode_settings.unsplit_output_mode = pins_ff.unsplit;
        // In 1:1 mode phase has no meaning, so it is forced to 0 degree
        nxt_mode_settings.output_phase_select = ~pins_ff.unsplit
            & (register_control_mode ? phase_bit_ff : pins_ff.phase);
        nxt_mode_settings.interleave = register_control_mode ? interleave_bit_ff
                                                             : pins_ff.interleave;
        nxt_mode_settings.range_i = nxt_range[0];
        nxt_mode_settings.range_q = nxt_range[1];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode_settings_ff <= '0;
        end else begin
            mode_settings_ff <= nxt_mode_settings;
        end
    end

    // Interrupt status: a new event wins over a clear in the same cycle
    assign irq_events[mode_ctrl_pkg::IRQ_TRIM_START] = trim_start;
    assign irq_events[mode_ctrl_pkg::IRQ_TRIM_DONE] = trim_done;
    assign irq_events[mode_ctrl_pkg::IRQ_MODE_CHANGE] =
        register_control_mode != mode_settings_ff.register_control_mode;
    assign irq_clear = (reg_write && reg_addr == mode_ctrl_pkg::ADDR_IRQ_CLEAR)
                       ? reg_wdata[IW-1:0] : mode_ctrl_pkg::IRQ_RESET;
    assign nxt_irq_status = (irq_status_ff & ~irq_clear) | irq_events;

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_status_ff <= mode_ctrl_pkg::IRQ_RESET;
            irq_ff <= 1'b0;
        end else begin
            irq_status_ff <= nxt_irq_status;
            irq_ff <= |(nxt_irq_status & irq_enable_ff);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_enable_ff <= mode_ctrl_pkg::IRQ_RESET;
        end else if (reg_write && reg_addr == mode_ctrl_pkg::ADDR_IRQ_ENABLE) begin
            irq_enable_ff <= reg_wdata[IW-1:0];
        end
    end

    // Read data stand for one cycle only; unmapped and write-only read zero
    always_ff @(posedge clk) begin
        if (reset || !reg_read) begin
            reg_rdata_ff <= mode_ctrl_pkg::DATA_ZERO;
        end else begin
            reg_rdata_ff <= mode_ctrl_pkg::DATA_ZERO;
            unique case (reg_addr)
                mode_ctrl_pkg::ADDR_CONFIG: begin
                    reg_rdata_ff[mode_ctrl_pkg::CFG_TRIGGER_BIT] <= trigger_bit_ff;
                    reg_rdata_ff[mode_ctrl_pkg::CFG_PHASE_BIT] <= phase_bit_ff;
                    reg_rdata_ff[mode_ctrl_pkg::CFG_INTERLEAVE_BIT] <= interleave_bit_ff;
                end
                mode_ctrl_pkg::ADDR_RANGE_I: begin
                    reg_rdata_ff[RW-1:0] <= range_ff[0];
                end
                mode_ctrl_pkg::ADDR_RANGE_Q: begin
                    reg_rdata_ff[RW-1:0] <= range_ff[1];
                end
                mode_ctrl_pkg::ADDR_IRQ_STATUS: begin
                    reg_rdata_ff[IW-1:0] <= irq_status_ff;
                end
                mode_ctrl_pkg::ADDR_IRQ_ENABLE: begin
                    reg_rdata_ff[IW-1:0] <= irq_enable_ff;
                end
                mode_ctrl_pkg::ADDR_LIVE_STATE: begin
                    reg_rdata_ff[0] <= selftrim_active_ff;
                    reg_rdata_ff[1] <= register_control_mode;
                    reg_rdata_ff[2] <= mode_settings_ff.output_phase_select;
                    reg_rdata_ff[3] <= mode_settings_ff.interleave;
                    reg_rdata_ff[4] <= mode_settings_ff.unsplit_output_mode;
                    reg_rdata_ff[5] <= trigger_armed_ff;
                end
                default: begin
                    reg_rdata_ff <= mode_ctrl_pkg::DATA_ZERO;
                end
            endcase
        end
    end

    assign reg_rdata = reg_rdata_ff;
    assign selftrim_active = selftrim_active_ff;
    assign mode_settings = mode_settings_ff;
    assign irq = irq_ff;

endmodule

// [mode_ctrl_pkg.sv]
// Constants, types and register map for the converter mode and self-trim control.
// Assumes a single 125 MHz clock and a plain register port with one-cycle strobes.
//
// How it works
// - A trigger held low one cycle beyond its minimum, then high its minimum, starts a self-trim.
// - A trigger already high at power-on blocks the automatic self-trim until cycled.
// - In register mode the pin ORs with the trigger bit; both low before a start.
// - The wait select pin picks the long or short power-on wait in any mode.
// - The self-trim active output is high exactly while a self-trim runs.
// - Phase select low gives 0 degree data-to-clock, high gives 90 degree.
// - Phase selection acts only while the output bus is split 1:2.
// - In register mode the phase comes from the phase bit, default 0 degree.
// - In pin mode the interleave pin makes both channels sample the in-phase input.
// - In register mode interleave comes from its register bit, default off.
// - Enable pin low selects register control; the phase, interleave and range pins are then ignored.
// - Enable pin high holds the config and range registers at defaults; the interrupt registers stay accessible.
// - In pin mode the range pin sets low or high range for both channels.
// - In register mode each channel takes its range from its own register.
// - Pin high range equals register middle code, pin low equals minimum code.
// - Unsplit pin high gives 1:1 output, low gives 1:2, in both modes.

package mode_ctrl_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int RANGE_W = 4;
    localparam int CNT_W = 24;
    localparam int IRQ_W = 3;
    localparam int CHANNELS = 2;

    // Register indices; the port addresses registers by index
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RANGE_I = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_RANGE_Q = 8'h0B;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'h11;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 8'h12;
    localparam logic [ADDR_W-1:0] ADDR_LIVE_STATE = 8'h13;

    localparam int CFG_TRIGGER_BIT = 15;
    localparam int CFG_PHASE_BIT = 14;
    localparam int CFG_INTERLEAVE_BIT = 7;

    localparam int IRQ_TRIM_START = 0;
    localparam int IRQ_TRIM_DONE = 1;
    localparam int IRQ_MODE_CHANGE = 2;

    localparam logic [RANGE_W-1:0] RANGE_MIN = 4'h0;
    localparam logic [RANGE_W-1:0] RANGE_MID = 4'h8;
    localparam logic [RANGE_W-1:0] RANGE_RESET = RANGE_MID;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

    localparam int CLK_PERIOD_PS = 8000;
    localparam int TRIGGER_MIN_LOW_NS = 80;
    localparam int TRIGGER_MIN_HIGH_NS = 80;
    localparam int POWERON_SHORT_US = 100;
    localparam int POWERON_LONG_US = 1000;
    localparam int TRIM_RUN_US = 40;

    // Least times round up to whole cycles
    localparam int TRIGGER_MIN_LOW_CYC = (TRIGGER_MIN_LOW_NS * 1000 + CLK_PERIOD_PS - 1)
                                         / CLK_PERIOD_PS;
    localparam int TRIGGER_MIN_HIGH_CYC = (TRIGGER_MIN_HIGH_NS * 1000 + CLK_PERIOD_PS - 1)
                                          / CLK_PERIOD_PS;
    localparam int POWERON_SHORT_CYC = (POWERON_SHORT_US * 1000000) / CLK_PERIOD_PS;
    localparam int POWERON_LONG_CYC = (POWERON_LONG_US * 1000000) / CLK_PERIOD_PS;
    localparam int TRIM_RUN_CYC = (TRIM_RUN_US * 1000000) / CLK_PERIOD_PS;
    localparam logic [CNT_W-1:0] SETTLE_LAST = 24'h00_0003;

    typedef struct packed {
        logic trigger;
        logic wait_select;
        logic phase;
        logic interleave;
        logic extended_control_enable_n;
        logic range;
        logic unsplit;
    } mode_pins_t;

    // Synchroniser contents during reset; the enable pin idles high, so pin control
    localparam mode_pins_t PINS_RESET = 7'h04;

    typedef struct packed {
        logic register_control_mode;
        logic output_phase_select;
        logic interleave;
        logic unsplit_output_mode;
        logic [RANGE_W-1:0] range_i;
        logic [RANGE_W-1:0] range_q;
    } mode_out_t;

    typedef enum logic [1:0] {
        ST_SETTLE,
        ST_PWR_WAIT,
        ST_IDLE,
        ST_RUN
    } trim_state_t;

endpackage

// [mode_ctrl_sva.sv]
// Checker for the mode and self-trim block, watching only its top-level ports.
// Assumes the bench hands the shortened self-trim run length on through the bind.
`timescale 1ns/1ps
module mode_ctrl_sva #(
    parameter int TRIM_RUN_CYC = 20
) (
    input wire logic clk,
    input wire logic reset,
    input wire mode_ctrl_pkg::mode_pins_t mode_pins,
    input wire logic [mode_ctrl_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [mode_ctrl_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [mode_ctrl_pkg::DATA_W-1:0] reg_rdata,
    input wire logic selftrim_active,
    input wire mode_ctrl_pkg::mode_out_t mode_settings,
    input wire logic irq
);
    logic [15:0] run_cnt_ff;
    logic [7:0] low_run_ff;
    always_ff @(posedge clk) begin
        if (reset || !selftrim_active) begin
            run_cnt_ff <= 16'h0000;
        end else begin
            run_cnt_ff <= run_cnt_ff + 16'h0001;
        end
    end
    // Raw pin low time; saturates so a long idle never wraps back under the bound
    always_ff @(posedge clk) begin
        if (reset || mode_pins.trigger) begin
            low_run_ff <= 8'h00;
        end else if (low_run_ff != 8'hFF) begin
            low_run_ff <= low_run_ff + 8'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    mode_follow_a: assert property ($stable(mode_pins)[*6] |->
        mode_settings.register_control_mode == !mode_pins.extended_control_enable_n)
        else $error("mode flag wrong");
    unsplit_follow_a: assert property ($stable(mode_pins)[*6] |->
        mode_settings.unsplit_output_mode == mode_pins.unsplit) else $error("unsplit wrong");
    phase_split_a: assert property (mode_settings.unsplit_output_mode |->
        !mode_settings.output_phase_select) else $error("phase set in 1:1 mode");
    pin_phase_a: assert property (($stable(mode_pins)[*6]
        ##0 mode_pins.extended_control_enable_n) |->
        mode_settings.output_phase_select == (mode_pins.phase && !mode_pins.unsplit))
        else $error("pin phase wrong");
    pin_interleave_a: assert property (($stable(mode_pins)[*6]
        ##0 mode_pins.extended_control_enable_n) |->
        mode_settings.interleave == mode_pins.interleave) else $error("pin interleave wrong");
    pin_range_a: assert property (($stable(mode_pins)[*6]
        ##0 mode_pins.extended_control_enable_n) |->
        mode_settings.range_i == (mode_pins.range ? 4'h8 : 4'h0)
        && mode_settings.range_q == mode_settings.range_i) else $error("pin range wrong");
    reg_hold_a: assert property ((!mode_pins.extended_control_enable_n
        && !reg_write && $stable(mode_pins.unsplit)
        && $stable(mode_pins.extended_control_enable_n))[*6] |->
        $stable(mode_settings)) else $error("register mode follows pins");
    trim_length_a: assert property ($fell(selftrim_active) && !$past(reset) |->
        run_cnt_ff == 16'(TRIM_RUN_CYC)) else $error("self-trim length wrong");
    trim_start_a: assert property ((mode_pins.extended_control_enable_n
        && !selftrim_active && low_run_ff >= 8'h10 && mode_pins.trigger
        ##1 mode_pins.trigger[*8]
        ##1 mode_pins.trigger[*6]) |-> ##[0:2] selftrim_active) else $error("no self-trim");
endmodule
bind converter_mode_pin_control mode_ctrl_sva #(.TRIM_RUN_CYC(TRIM_RUN_CYC)) u_mode_ctrl_sva (
    .clk(clk), .reset(reset), .mode_pins(mode_pins), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .selftrim_active(selftrim_active), .mode_settings(mode_settings), .irq(irq));

// [board_pins.sv]
// Board-side pin driver: passes the bench's levels and, on request, cycles the trigger.
// Assumes cycle_trig is one clock long; pins change only just after rising edges.
`timescale 1ns/1ps
module board_pins (
    input wire logic clk,
    input wire mode_ctrl_pkg::mode_pins_t want,
    input wire logic cycle_trig,
    output mode_ctrl_pkg::mode_pins_t pins
);
    mode_ctrl_pkg::mode_pins_t pins_ff = 7'h04;
    logic [4:0] cnt_ff = 5'h00;
    assign pins = pins_ff;
    // Low 18 cycles then high 12: both beyond the least times, with margin for sync
    always_ff @(posedge clk) begin
        cnt_ff <= cycle_trig ? 5'h1E : (cnt_ff != 5'h00 ? cnt_ff - 5'h01 : 5'h00);
        pins_ff <= want;
        if (cnt_ff > 5'h0C) begin
            pins_ff.trigger <= 1'b0;
        end else if (cnt_ff != 5'h00) begin
            pins_ff.trigger <= 1'b1;
        end
    end
endmodule

// [tb.sv]
// Self-checking bench for the mode and self-trim block, with short power-on waits.
// Assumes the package constants and board_pins as the pin driver.
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    mode_ctrl_pkg::mode_pins_t want = 7'h04;
    mode_ctrl_pkg::mode_pins_t pins;
    logic cycle_trig = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic selftrim_active;
    mode_ctrl_pkg::mode_out_t mode_settings;
    logic irq;
    logic [15:0] rd_data;
    int n_fail = 0;
    int checked = 0;
    int n;
    always #4 clk = ~clk;
    board_pins u_board_pins (.clk(clk), .want(want), .cycle_trig(cycle_trig), .pins(pins));
    converter_mode_pin_control #(.POWERON_SHORT_CYC(40), .POWERON_LONG_CYC(80),
        .TRIM_RUN_CYC(20)) u_converter_mode_pin_control (.clk(clk), .reset(reset),
        .mode_pins(pins), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .selftrim_active(selftrim_active),
        .mode_settings(mode_settings), .irq(irq));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        rd_data = reg_rdata;
    endtask
    // Leaves in n the cycles waited, lim meaning no self-trim seen
    task automatic wait_trim(input int lim);
        n = 0;
        @(negedge clk);
        while (selftrim_active !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic wait_idle;
        n = 0;
        while (selftrim_active === 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic set_pins(input logic [6:0] p, input logic rst, input logic trig);
        @(posedge clk);
        want <= p;
        reset <= rst;
        cycle_trig <= trig;
    endtask
    task automatic do_reset(input logic [6:0] p);
        set_pins(p, 1'b1, 1'b0);
        cyc(8);
        reset <= 1'b0;
    endtask
    task automatic t_poweron;
        do_reset(7'h04);
        wait_trim(100);
        chk("short wait", 16'h0001, 16'(n >= 40 && n <= 52));
        wait_idle;
        chk("run length", 16'h0014, 16'(n));
        do_reset(7'h24);
        wait_trim(150);
        chk("long wait", 16'h0001, 16'(n >= 80 && n <= 92));
        wait_idle;
    endtask
    task automatic t_held;
        do_reset(7'h44);
        wait_trim(150);
        chk("held trigger", 16'h0096, 16'(n));
        set_pins(7'h44, 1'b0, 1'b1);
        set_pins(7'h44, 1'b0, 1'b0);
        wait_trim(60);
        chk("cycled trigger", 16'h0001, 16'(n < 60));
        wait_idle;
        set_pins(7'h04, 1'b0, 1'b0);
        cyc(20);
        set_pins(7'h44, 1'b0, 1'b0);
        cyc(4);
        set_pins(7'h04, 1'b0, 1'b0);
        wait_trim(40);
        chk("short pulse", 16'h0028, 16'(n));
    endtask
    task automatic t_pins;
        for (int i = 0; i < 16; i++) begin
            set_pins({2'b00, i[2], i[3], 1'b1, i[1], i[0]}, 1'b0, 1'b0);
            cyc(6);
            @(negedge clk);
            chk("pin modes", {5'h00, i[2] & ~i[0], i[3], i[0], {2{i[1], 3'b000}}},
                16'(mode_settings));
        end
    endtask
    task automatic t_regs;
        set_pins(7'h1A, 1'b0, 1'b0);
        cyc(6);
        @(negedge clk);
        chk("register defaults", 16'h0888, 16'(mode_settings));
        wr(8'h03, 16'h000C);
        wr(8'h0B, 16'h0003);
        wr(8'h00, 16'h4080);
        cyc(3);
        @(negedge clk);
        chk("register modes", 16'h0EC3, 16'(mode_settings));
        rd(8'h03);
        chk("range i", 16'h000C, rd_data);
        rd(8'h0B);
        chk("range q", 16'h0003, rd_data);
        rd(8'h20);
        chk("unmapped", 16'h0000, rd_data);
        wr(8'h11, 16'h0003);
        wr(8'h12, 16'h0007);
        wr(8'h00, 16'hC080);
        wait_trim(40);
        chk("bit trigger", 16'h0001, 16'(n < 40));
        chk("irq start", 16'h0001, 16'(irq));
        wr(8'h12, 16'h0001);
        wait_idle;
        cyc(2);
        rd(8'h10);
        chk("irq status", 16'h0002, rd_data);
        chk("irq done", 16'h0001, 16'(irq));
        wr(8'h11, 16'h0000);
        cyc(1);
        @(negedge clk);
        chk("irq masked", 16'h0000, 16'(irq));
        rd(8'h13);
        chk("live state", 16'h000E, rd_data);
        set_pins(7'h1E, 1'b0, 1'b0);
        cyc(6);
        rd(8'h03);
        chk("range reset", 16'h0008, rd_data);
        rd(8'h00);
        chk("config reset", 16'h0000, rd_data);
        rd(8'h10);
        chk("mode change status", 16'h0006, rd_data);
    endtask
    task automatic give_verdict;
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        t_poweron;
        t_held;
        t_pins;
        t_regs;
        give_verdict;
    end
    initial begin
        cyc(20000);
        n_fail++;
        give_verdict;
    end
endmodule
